// File: rtl/pfc_pkg.sv
// Package: register map, field layout and shared types of the packet format control block
package pfc_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [9:0] PFC_ADDR_RX_BASE  = 10'h125;
  localparam logic [9:0] PFC_ADDR_FMT_CFG  = 10'h126;
  localparam logic [9:0] PFC_ADDR_LEN_MAX  = 10'h127;
  localparam logic [9:0] PFC_ADDR_IRQ_STAT = 10'h140;
  localparam logic [9:0] PFC_ADDR_IRQ_MASK = 10'h141;
  localparam logic [9:0] PFC_ADDR_STATUS   = 10'h142;

  // ==========================================================================
  // Field positions of packet_format_config
  localparam int PFC_BIT_BYTE_ORDER = 7;
  localparam int PFC_BIT_LEN_MODE   = 6;
  localparam int PFC_BIT_CRC_EN     = 5;
  localparam int PFC_MODE_HI        = 4;
  localparam int PFC_MODE_LO        = 3;
  localparam int PFC_OFS_HI         = 2;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] PFC_RST_RX_BASE = 8'h00;
  localparam logic [7:0] PFC_RST_FMT_CFG = 8'h00;
  localparam logic [7:0] PFC_RST_LEN_MAX = 8'hF0;
  localparam logic [3:0] PFC_RST_MASK    = 4'h0;

  // Fixed subtrahend of the payload length formula
  localparam logic [8:0] PFC_LEN_BIAS = 9'h004;

  // Interrupt status bit positions
  localparam int PFC_IRQ_TX_DONE  = 0;
  localparam int PFC_IRQ_RX_DONE  = 1;
  localparam int PFC_IRQ_CRC_ERR  = 2;
  localparam int PFC_IRQ_DETECT   = 3;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    PFC_MODE_PACKET  = 2'h0,
    PFC_MODE_SP_PRE  = 2'h1,
    PFC_MODE_SP_SYNC = 2'h2,
    PFC_MODE_UNUSED  = 2'h3
  } pfc_mode_type;

  typedef struct packed {
    logic         msb_first;
    logic         fixed_len;
    logic         crc_en;
    pfc_mode_type mode;
    logic [2:0]   len_offset;
  } pfc_cfg_type;

  typedef struct packed {
    logic       req;
    logic       we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pfc_ram_req_type;

endpackage : pfc_pkg

// File: rtl/pfc_ser.sv
// Bit serialiser: one byte out over the air, order chosen per byte
`timescale 1ns/1ps
module pfc_ser
  import pfc_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             srst_i,
  // Byte side
  input  wire logic             load_i,
  input  wire logic [WIDTH-1:0] byte_i,
  input  wire logic             msb_first_i,
  input  wire logic             bit_en_i,
  output logic                  busy_o,
  output logic                  done_o,
  // Air side
  output logic                  bit_o,
  output logic                  bit_vld_o
);

  logic [WIDTH-1:0] sh_q;
  logic [$clog2(WIDTH+1)-1:0] cnt_q;
  logic             msb_q;

  // ==========================================================================
  // Shift engine; order latched with the byte so a mid-byte change is harmless
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      sh_q      <= '0;
      cnt_q     <= '0;
      msb_q     <= 1'b0;
      bit_o     <= 1'b0;
      bit_vld_o <= 1'b0;
      done_o    <= 1'b0;
    end else begin
      bit_vld_o <= 1'b0;
      done_o    <= 1'b0;
      if (load_i && cnt_q == '0) begin
        sh_q  <= byte_i;
        msb_q <= msb_first_i;
        cnt_q <= ($clog2(WIDTH+1))'(WIDTH);
      end else if (bit_en_i && cnt_q != '0) begin
        bit_o     <= msb_q ? sh_q[WIDTH-1] : sh_q[0];
        bit_vld_o <= 1'b1;
        sh_q      <= msb_q ? {sh_q[WIDTH-2:0], 1'b0} : {1'b0, sh_q[WIDTH-1:1]};
        cnt_q     <= cnt_q - 1'b1;
        done_o    <= (cnt_q == 1);
      end
    end
  end

  assign busy_o = (cnt_q != '0);

endmodule // pfc_ser

// File: rtl/pfc_des.sv
// Bit deserialiser: one byte in from the air, order taken from msb_first_i at every bit
`timescale 1ns/1ps
module pfc_des
  import pfc_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             srst_i,
  // Control
  input  wire logic             clear_i,
  input  wire logic             msb_first_i,
  // Air side
  input  wire logic             bit_i,
  input  wire logic             bit_vld_i,
  // Byte side
  output logic [WIDTH-1:0]      byte_o,
  output logic                  byte_vld_o
);

  logic [WIDTH-1:0] sh_q;
  logic [$clog2(WIDTH+1)-1:0] cnt_q;

  // ==========================================================================
  // Assemble bits; a full byte is presented for one cycle
  always_ff @(posedge sys_clk_i) begin
    if (srst_i || clear_i) begin
      sh_q       <= '0;
      cnt_q      <= '0;
      byte_o     <= '0;
      byte_vld_o <= 1'b0;
    end else begin
      byte_vld_o <= 1'b0;
      if (bit_vld_i) begin
        if (cnt_q == ($clog2(WIDTH+1))'(WIDTH - 1)) begin
          cnt_q      <= '0;
          byte_vld_o <= 1'b1;
          byte_o     <= msb_first_i ? {sh_q[WIDTH-2:0], bit_i}
                                    : {bit_i, sh_q[WIDTH-1:1]};
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
        sh_q <= msb_first_i ? {sh_q[WIDTH-2:0], bit_i} : {bit_i, sh_q[WIDTH-1:1]};
      end
    end
  end

endmodule // pfc_des

// File: rtl/pfc_top.sv
// Packet format control: configuration registers, packet RAM framing and air bit order
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps

module pfc_top
  import pfc_pkg::*;
#(
  parameter int AW = 10
) (
  // Clock and reset
  input  wire logic          sys_clk_i,
  input  wire logic          srst_i,
  // Register port
  input  wire logic [AW-1:0] reg_addr_i,
  input  wire logic [7:0]    reg_wdata_i,
  input  wire logic          reg_wr_i,
  input  wire logic          reg_rd_i,
  output logic      [7:0]    reg_rdata_o,
  // Packet commands
  input  wire logic          tx_start_i,
  input  wire logic [7:0]    tx_base_i,
  input  wire logic          rx_start_i,
  input  wire logic          rx_qualified_i,
  // Packet RAM
  output pfc_ram_req_type    ram_req_o,
  input  wire logic [7:0]    ram_rdata_i,
  // CRC engine
  output logic               crc_en_o,
  input  wire logic          crc_ok_i,
  // Air link
  input  wire logic          bit_en_i,
  output logic               tx_bit_o,
  output logic               tx_bit_vld_o,
  input  wire logic          rx_bit_i,
  input  wire logic          rx_bit_vld_i,
  input  wire logic          preamble_det_i,
  input  wire logic          sync_det_i,
  // Streaming output
  output logic               stream_bit_o,
  output logic               stream_vld_o,
  // Status
  output logic      [8:0]    payload_len_o,
  output logic               tx_busy_o,
  output logic               rx_busy_o,
  output logic               general_purpose_irq_out_o,
  output logic               irq_o
);

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_TXRD  = 3'b001,
    ST_TXSH  = 3'b011,
    ST_TXEND = 3'b010,
    ST_RXHD  = 3'b110,
    ST_RXBY  = 3'b111,
    ST_RXEND = 3'b101
  } pfc_state_type;

  // ==========================================================================
  // Registers
  logic [7:0]    rx_base_q;
  logic [7:0]    fmt_cfg_q;
  logic [7:0]    len_max_q;
  logic [3:0]    irq_stat_q;
  logic [3:0]    irq_mask_q;
  pfc_cfg_type   cfg_q;
  logic [7:0]    len_term_q;
  logic [8:0]    payload_q;
  logic [7:0]    ptr_q;
  logic [8:0]    left_q;
  pfc_state_type st_q;
  logic          rd_pend_q;
  logic          streaming_q;
  logic [3:0]    ev_set;
  logic          wr_hit;
  logic          ser_load;
  logic          ser_busy;
  logic          ser_done;
  logic [7:0]    rx_byte;
  logic          rx_byte_vld;
  logic          stream_mode;
  logic          pre_strm;
  logic [8:0]    len_calc;

  assign wr_hit = reg_wr_i;

  // ==========================================================================
  // Configuration registers
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      rx_base_q  <= PFC_RST_RX_BASE;
      fmt_cfg_q  <= PFC_RST_FMT_CFG;
      len_max_q  <= PFC_RST_LEN_MAX;
      irq_mask_q <= PFC_RST_MASK;
    end else if (wr_hit) begin
      case (reg_addr_i)
        PFC_ADDR_RX_BASE:  rx_base_q  <= reg_wdata_i;
        PFC_ADDR_FMT_CFG:  fmt_cfg_q  <= reg_wdata_i;
        PFC_ADDR_LEN_MAX:  len_max_q  <= reg_wdata_i;
        PFC_ADDR_IRQ_MASK: irq_mask_q <= reg_wdata_i[3:0];
        default:           ;
      endcase
    end
  end

  // Sticky events; a set in the clearing cycle survives
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      irq_stat_q <= '0;
    end else if (wr_hit && reg_addr_i == PFC_ADDR_IRQ_STAT) begin
      irq_stat_q <= (irq_stat_q & ~reg_wdata_i[3:0]) | ev_set;
    end else begin
      irq_stat_q <= irq_stat_q | ev_set;
    end
  end

  assign irq_o = |(irq_stat_q & irq_mask_q);

  // ==========================================================================
  // Read port: data the cycle after the strobe, unmapped reads zero
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        PFC_ADDR_RX_BASE:  reg_rdata_o <= rx_base_q;
        PFC_ADDR_FMT_CFG:  reg_rdata_o <= fmt_cfg_q;
        PFC_ADDR_LEN_MAX:  reg_rdata_o <= len_max_q;
        PFC_ADDR_IRQ_STAT: reg_rdata_o <= {4'h0, irq_stat_q};
        PFC_ADDR_IRQ_MASK: reg_rdata_o <= {4'h0, irq_mask_q};
        PFC_ADDR_STATUS:   reg_rdata_o <= {5'h00, streaming_q, rx_busy_o, tx_busy_o};
        default:           reg_rdata_o <= '0;
      endcase
    end else begin
      reg_rdata_o <= '0;
    end
  end

  // ==========================================================================
  // Payload length: length term plus offset minus four, never below zero
  always_comb begin
    len_calc = {1'b0, len_term_q} + {6'h00, cfg_q.len_offset};
    len_calc = (len_calc > PFC_LEN_BIAS) ? len_calc - PFC_LEN_BIAS : '0;
  end

  assign stream_mode = (cfg_q.mode == PFC_MODE_SP_PRE) ||
                       (cfg_q.mode == PFC_MODE_SP_SYNC);
  assign pre_strm    = fmt_cfg_q[PFC_MODE_HI] ^ fmt_cfg_q[PFC_MODE_LO];
  assign tx_busy_o   = (st_q == ST_TXRD) || (st_q == ST_TXSH) || (st_q == ST_TXEND);
  assign rx_busy_o   = (st_q == ST_RXHD) || (st_q == ST_RXBY) || (st_q == ST_RXEND);
  assign crc_en_o    = cfg_q.crc_en;
  assign payload_len_o = payload_q;

  // ==========================================================================
  // Packet sequencer
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      st_q       <= ST_IDLE;
      cfg_q      <= '0;
      len_term_q <= '0;
      payload_q  <= '0;
      ptr_q      <= '0;
      left_q     <= '0;
      rd_pend_q  <= 1'b0;
      ram_req_o  <= '0;
      ev_set     <= '0;
    end else begin
      ram_req_o <= '0;
      ev_set    <= '0;
      rd_pend_q <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          // Latch format once per packet; later writes wait for the next one
          if (tx_start_i && fmt_cfg_q[PFC_MODE_HI:PFC_MODE_LO] == 2'h0) begin
            cfg_q      <= pfc_cfg_type'(fmt_cfg_q);
            ptr_q      <= tx_base_i;
            len_term_q <= len_max_q;
            left_q     <= '0;
            st_q       <= ST_TXRD;
          end else if (rx_start_i && fmt_cfg_q[PFC_MODE_HI:PFC_MODE_LO] == 2'h0) begin
            cfg_q      <= pfc_cfg_type'(fmt_cfg_q);
            ptr_q      <= rx_base_q;
            len_term_q <= len_max_q;
            st_q       <= fmt_cfg_q[PFC_BIT_LEN_MODE] ? ST_RXBY : ST_RXHD;
            left_q     <= '0;
          end else if (preamble_det_i) begin
            cfg_q <= pfc_cfg_type'(fmt_cfg_q);
          end
        end
        ST_TXRD: begin
          // Fetch one byte; first byte of a variable packet is its length
          if (!rd_pend_q && !ser_busy) begin
            ram_req_o <= '{req: 1'b1, we: 1'b0, addr: ptr_q, wdata: 8'h00};
            rd_pend_q <= 1'b1;
          end else if (rd_pend_q) begin
            st_q <= ST_TXSH;
          end
        end
        ST_TXSH: begin
          // Variable packets take their length from the byte being loaded
          if (ser_load && !cfg_q.fixed_len && left_q == '0 && ptr_q == tx_base_i) begin
            len_term_q <= ram_rdata_i;
          end
          if (ser_done) begin
            ptr_q <= ptr_q + 8'h01;
            if (left_q == '0 && ptr_q == tx_base_i) begin
              // Length counted from end of sync word to start of CRC
              left_q <= {1'b0, len_term_q} - 9'h001;
              st_q   <= (len_term_q > 8'h01) ? ST_TXRD : ST_TXEND;
            end else if (left_q > 9'h001) begin
              left_q <= left_q - 9'h001;
              st_q   <= ST_TXRD;
            end else begin
              st_q <= ST_TXEND;
            end
          end
        end
        ST_TXEND: begin
          // Publish the count and flag completion
          payload_q <= len_calc;
          ev_set[PFC_IRQ_TX_DONE] <= 1'b1;
          st_q <= ST_IDLE;
        end
        ST_RXHD: begin
          // First byte is the length and is stored too
          if (rx_byte_vld) begin
            len_term_q <= rx_byte;
            left_q     <= {1'b0, rx_byte} - 9'h001;
            ram_req_o  <= '{req: 1'b1, we: 1'b1, addr: ptr_q, wdata: rx_byte};
            ptr_q      <= ptr_q + 8'h01;
            st_q       <= (rx_byte > 8'h01) ? ST_RXBY : ST_RXEND;
          end
        end
        ST_RXBY: begin
          // Fixed receive: count loaded from the latched length
          if (left_q == '0 && cfg_q.fixed_len && ptr_q == rx_base_q) begin
            left_q <= {1'b0, len_term_q};
          end else if (rx_byte_vld) begin
            ram_req_o <= '{req: 1'b1, we: 1'b1, addr: ptr_q, wdata: rx_byte};
            ptr_q     <= ptr_q + 8'h01;
            left_q    <= left_q - 9'h001;
            if (left_q <= 9'h001) begin
              st_q <= ST_RXEND;
            end
          end
        end
        ST_RXEND: begin
          // Completion only once qualified; a CRC fault flags an error instead
          if (rx_qualified_i) begin
            payload_q <= len_calc;
            if (cfg_q.crc_en && !crc_ok_i) begin
              ev_set[PFC_IRQ_CRC_ERR] <= 1'b1;
            end else begin
              ev_set[PFC_IRQ_RX_DONE] <= 1'b1;
            end
            st_q <= ST_IDLE;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
      if (general_purpose_irq_out_o) begin
        ev_set[PFC_IRQ_DETECT] <= 1'b1;
      end
    end
  end

  // Done blocks a reload in the cycle the byte ends
  assign ser_load = (st_q == ST_TXSH) && !ser_busy && !ser_done;

  // ==========================================================================
  // Streaming: data released from preamble detection in both streaming modes
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      streaming_q               <= 1'b0;
      stream_bit_o              <= 1'b0;
      stream_vld_o              <= 1'b0;
      general_purpose_irq_out_o <= 1'b0;
    end else begin
      general_purpose_irq_out_o <= 1'b0;
      stream_vld_o              <= 1'b0;
      // Preamble uses the live format register, since cfg_q only takes it at this same edge
      if (st_q == ST_IDLE && preamble_det_i && pre_strm) begin
        streaming_q <= 1'b1;
        if (fmt_cfg_q[PFC_MODE_LO]) begin
          general_purpose_irq_out_o <= 1'b1;
        end
      end else if (!stream_mode) begin
        streaming_q <= 1'b0;
      end
      if (st_q == ST_IDLE && stream_mode && sync_det_i) begin
        if (cfg_q.mode == PFC_MODE_SP_SYNC) begin
          general_purpose_irq_out_o <= 1'b1;
        end
      end
      if (streaming_q && rx_bit_vld_i) begin
        stream_bit_o <= rx_bit_i;
        stream_vld_o <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Bit order engines
  pfc_ser #(.WIDTH(8)) u_ser (
    .sys_clk_i   (sys_clk_i),
    .srst_i      (srst_i),
    .load_i      (ser_load),
    .byte_i      (ram_rdata_i),
    .msb_first_i (cfg_q.msb_first),
    .bit_en_i    (bit_en_i),
    .busy_o      (ser_busy),
    .done_o      (ser_done),
    .bit_o       (tx_bit_o),
    .bit_vld_o   (tx_bit_vld_o)
  );

  pfc_des #(.WIDTH(8)) u_des (
    .sys_clk_i   (sys_clk_i),
    .srst_i      (srst_i),
    .clear_i     (st_q == ST_IDLE),
    .msb_first_i (cfg_q.msb_first),
    .bit_i       (rx_bit_i),
    .bit_vld_i   (rx_bit_vld_i),
    .byte_o      (rx_byte),
    .byte_vld_o  (rx_byte_vld)
  );

endmodule // pfc_top

// File: testbench/pfc_chk.sv
// Checker: port-level properties of the packet format control block
`timescale 1ns/1ps
module pfc_chk
  import pfc_pkg::*;
#(
  parameter int AW = 10
) (
  // Clock, reset and register port
  input wire logic            sys_clk_i,
  input wire logic            srst_i,
  input wire logic [AW-1:0]   reg_addr_i,
  input wire logic [7:0]      reg_wdata_i,
  input wire logic            reg_wr_i,
  // Packet side
  input wire logic            tx_start_i,
  input wire logic [7:0]      tx_base_i,
  input wire logic            rx_start_i,
  input wire pfc_ram_req_type ram_req_o,
  input wire logic            crc_en_o,
  input wire logic            tx_bit_vld_o,
  // Detection and status
  input wire logic            preamble_det_i,
  input wire logic            sync_det_i,
  input wire logic            tx_busy_o,
  input wire logic            rx_busy_o,
  input wire logic            general_purpose_irq_out_o
);
  // ==========================================================================
  // Shadow registers
  logic [7:0] cfg_q;
  logic [7:0] base_q;
  logic       first_q;
  wire        idle = !tx_busy_o && !rx_busy_o;
  wire  [1:0] mode = cfg_q[4:3];

  // Copies kept from the bus, so expectations lean on the design's state only through its busy outputs and its RAM write requests
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      cfg_q   <= 8'h00;
      base_q  <= 8'h00;
      first_q <= 1'b0;
    end else begin
      if (reg_wr_i && reg_addr_i == PFC_ADDR_FMT_CFG) cfg_q <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == PFC_ADDR_RX_BASE) base_q <= reg_wdata_i;
      if (rx_start_i && idle && mode == 2'h0) first_q <= 1'b1;
      else if (ram_req_o.req && ram_req_o.we) first_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Properties
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  AST_RX_TO_BASE: assert property (ram_req_o.req && ram_req_o.we && first_q
    |-> ram_req_o.addr == base_q) else $error("first receive write off base");
  AST_TX_FROM_BASE: assert property (tx_start_i && idle && mode == 2'h0
    |-> ##[1:3] (ram_req_o.req && !ram_req_o.we && ram_req_o.addr == tx_base_i))
    else $error("transmit did not read its first byte");
  AST_TX_NEEDS_PACKET: assert property (tx_start_i && idle && mode != 2'h0
    |=> !tx_busy_o) else $error("transmit taken in streaming mode");
  AST_RX_STARTS: assert property (rx_start_i && idle && mode == 2'h0
    |=> rx_busy_o) else $error("receive not started in packet mode");
  AST_CRC_LATCH: assert property (rx_start_i && idle && mode == 2'h0
    |=> crc_en_o == $past(cfg_q[5])) else $error("crc enable not latched");
  AST_GP_PREAMBLE: assert property (preamble_det_i && idle && mode == 2'h1
    |-> ##[1:3] general_purpose_irq_out_o) else $error("no pulse on preamble");
  AST_GP_NOT_PREAMBLE: assert property (preamble_det_i && !sync_det_i && mode == 2'h2
    |=> !general_purpose_irq_out_o) else $error("pulse on preamble in mode two");
  AST_GP_ONE: assert property (general_purpose_irq_out_o
    |=> !general_purpose_irq_out_o) else $error("interrupt pulse too long");
  AST_TX_BIT_IN_PACKET: assert property (tx_bit_vld_o |-> $past(tx_busy_o))
    else $error("air bit outside a transmit");
  AST_RAM_PULSE: assert property (ram_req_o.req |=> !ram_req_o.req)
    else $error("ram request longer than one cycle");

  COV_TX: cover property (tx_start_i && idle && mode == 2'h0);
  COV_RX: cover property (rx_start_i && idle && mode == 2'h0);
  COV_GP: cover property (general_purpose_irq_out_o);
endmodule // pfc_chk

bind pfc_top pfc_chk #(.AW(AW)) chk_u (.sys_clk_i, .srst_i, .reg_addr_i, .reg_wdata_i,
  .reg_wr_i, .tx_start_i, .tx_base_i, .rx_start_i, .ram_req_o, .crc_en_o, .tx_bit_vld_o,
  .preamble_det_i, .sync_det_i, .tx_busy_o, .rx_busy_o, .general_purpose_irq_out_o);

// File: testbench/pfc_far.sv
// Far-side model: packet RAM and the remote end of the air link
`timescale 1ns/1ps
module pfc_far
  import pfc_pkg::*;
(
  // Clock
  input  wire logic            sys_clk_i,
  // Packet RAM
  input  wire pfc_ram_req_type ram_req_i,
  output logic [7:0]           ram_rdata_o,
  // Air link
  output logic                 bit_en_o,
  output logic                 rx_bit_o,
  output logic                 rx_bit_vld_o,
  input  wire logic            tx_bit_i,
  input  wire logic            tx_bit_vld_i
);
  logic [7:0] mem [256];
  logic [7:0] cap_q;
  logic [1:0] div_q = 2'h0;

  // Known start contents; bytes equal their address
  initial begin
    ram_rdata_o  = 8'h00;
    rx_bit_o     = 1'b0;
    rx_bit_vld_o = 1'b0;
    for (int i = 0; i < 256; i++) mem[i] = 8'(i);
  end

  // Read data valid only after a read; toggles otherwise so stale data shows
  always @(posedge sys_clk_i) begin
    if (ram_req_i.req && !ram_req_i.we) ram_rdata_o <= mem[ram_req_i.addr];
    else ram_rdata_o <= ~ram_rdata_o;
    if (ram_req_i.req && ram_req_i.we) mem[ram_req_i.addr] <= ram_req_i.wdata;
    if (tx_bit_vld_i) cap_q <= {cap_q[6:0], tx_bit_i};
    div_q <= div_q + 2'h1;
  end

  // Bit rate is a quarter of the clock
  assign bit_en_o = (div_q == 2'h3);

  // Remote transmitter; the line shows the inverse once a bit is over
  task automatic send_byte(input logic [7:0] b, input logic msb);
    for (int i = 0; i < 8; i++) begin
      repeat (3) @(posedge sys_clk_i);
      rx_bit_o     <= msb ? b[7-i] : b[i];
      rx_bit_vld_o <= 1'b1;
      @(posedge sys_clk_i);
      rx_bit_vld_o <= 1'b0;
      rx_bit_o     <= ~rx_bit_o;
    end
  endtask
endmodule // pfc_far

// File: testbench/tb.sv
// Testbench: register, transmit, receive and streaming checks of pfc_top
`timescale 1ns/1ps
module tb;
  import pfc_pkg::*;
  // ==========================================================================
  // Signals
  logic            sys_clk_i = 1'b0;
  logic            srst_i = 1'b1;
  logic [9:0]      reg_addr_i = 10'h000;
  logic [7:0]      reg_wdata_i = 8'h00;
  logic [7:0]      tx_base_i = 8'h00;
  logic            reg_wr_i = 1'b0, reg_rd_i = 1'b0, tx_start_i = 1'b0, rx_start_i = 1'b0;
  logic            rx_qualified_i = 1'b0, crc_ok_i = 1'b0;
  logic            preamble_det_i = 1'b0, sync_det_i = 1'b0;
  logic [7:0]      reg_rdata_o, ram_rdata_i, sb_q;
  pfc_ram_req_type ram_req_o;
  logic            crc_en_o, bit_en_i, tx_bit_o, tx_bit_vld_o, rx_bit_i, rx_bit_vld_i;
  logic            stream_bit_o, stream_vld_o, tx_busy_o, rx_busy_o;
  logic            general_purpose_irq_out_o, irq_o;
  logic [8:0]      payload_len_o;
  int              fail_count = 0, cmp_count = 0, gp_n = 0, sv_n = 0;

  always #12.5 sys_clk_i = ~sys_clk_i;

  pfc_top dut_u (.sys_clk_i, .srst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .tx_start_i, .tx_base_i, .rx_start_i, .rx_qualified_i, .ram_req_o,
    .ram_rdata_i, .crc_en_o, .crc_ok_i, .bit_en_i, .tx_bit_o, .tx_bit_vld_o, .rx_bit_i,
    .rx_bit_vld_i, .preamble_det_i, .sync_det_i, .stream_bit_o, .stream_vld_o,
    .payload_len_o, .tx_busy_o, .rx_busy_o, .general_purpose_irq_out_o, .irq_o);
  pfc_far far_u (.sys_clk_i, .ram_req_i(ram_req_o), .ram_rdata_o(ram_rdata_i),
    .bit_en_o(bit_en_i), .rx_bit_o(rx_bit_i), .rx_bit_vld_o(rx_bit_vld_i),
    .tx_bit_i(tx_bit_o), .tx_bit_vld_i(tx_bit_vld_o));

  // Pulse and stream monitors
  always @(posedge sys_clk_i) begin
    if (general_purpose_irq_out_o === 1'b1) gp_n++;
    if (stream_vld_o === 1'b1) sv_n++;
    if (stream_vld_o === 1'b1) sb_q <= {sb_q[6:0], stream_bit_o};
  end

  // ==========================================================================
  // Tasks
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic do_reset();
    srst_i <= 1'b1;
    repeat (6) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask

  // Bus cycles end one edge later, so no strobe is driven twice in a step
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask

  task automatic rd(input logic [9:0] a, input logic [7:0] exp);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1 chk({1'b0, reg_rdata_o}, {1'b0, exp});
    @(posedge sys_clk_i);
  endtask

  task automatic pulse(input logic [3:0] w);
    {tx_start_i, rx_start_i, preamble_det_i, sync_det_i} <= w;
    @(posedge sys_clk_i);
    {tx_start_i, rx_start_i, preamble_det_i, sync_det_i} <= 4'h0;
    @(posedge sys_clk_i);
  endtask

  // Bounded wait for the packet sequencer to leave its transmit and receive states
  task automatic wait_idle();
    int n;
    n = 0;
    #1;
    while ((tx_busy_o !== 1'b0 || rx_busy_o !== 1'b0) && n < 3000) begin
      @(posedge sys_clk_i);
      #1 n++;
    end
    if (n == 3000) begin
      fail_count++;
      $display("Error at %0t: busy wait ran out", $time);
      close_out();
    end
    @(posedge sys_clk_i);
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    do_reset();
    rd(PFC_ADDR_RX_BASE, PFC_RST_RX_BASE);
    rd(PFC_ADDR_FMT_CFG, PFC_RST_FMT_CFG);
    rd(PFC_ADDR_LEN_MAX, PFC_RST_LEN_MAX);
    rd(PFC_ADDR_IRQ_MASK, 8'h00);
    rd(10'h1FF, 8'h00);
    wr(PFC_ADDR_RX_BASE, 8'h5A);
    rd(PFC_ADDR_RX_BASE, 8'h5A);
    $display("Test registers done");
    // Fixed single byte; the mid-packet write to LSB first must wait a packet
    far_u.mem[8'h10] = 8'h1E;
    far_u.mem[8'h20] = 8'h06;
    tx_base_i <= 8'h10;
    wr(PFC_ADDR_LEN_MAX, 8'h01);
    wr(PFC_ADDR_FMT_CFG, 8'hC4);
    pulse(4'h8);
    wr(PFC_ADDR_FMT_CFG, 8'h44);
    wait_idle();
    chk({1'b0, far_u.cap_q}, 9'h01E);
    chk(payload_len_o, 9'h001);
    rd(PFC_ADDR_IRQ_STAT, 8'h01);
    wr(PFC_ADDR_IRQ_MASK, 8'h01);
    #1 chk({8'h00, irq_o}, 9'h001);
    @(posedge sys_clk_i);
    wr(PFC_ADDR_IRQ_STAT, 8'h01);
    rd(PFC_ADDR_IRQ_STAT, 8'h00);
    pulse(4'h8);
    wait_idle();
    chk({1'b0, far_u.cap_q}, 9'h078);
    // Variable length: first byte gives the length
    tx_base_i <= 8'h20;
    wr(PFC_ADDR_FMT_CFG, 8'h82);
    pulse(4'h8);
    wait_idle();
    chk(payload_len_o, 9'h004);
    wr(PFC_ADDR_IRQ_STAT, 8'h0F);
    $display("Test transmit done");
    // Fixed two-byte receive, CRC checked then not, both bit orders
    rx_qualified_i <= 1'b1;
    wr(PFC_ADDR_LEN_MAX, 8'h02);
    for (int k = 0; k < 2; k++) begin
      wr(PFC_ADDR_RX_BASE, 8'h40 + 8'(k * 16));
      wr(PFC_ADDR_FMT_CFG, (k == 0) ? 8'hE5 : 8'h45);
      pulse(4'h4);
      far_u.send_byte(8'h3C, k == 0);
      far_u.send_byte(8'hC1, k == 0);
      wait_idle();
      chk({1'b0, far_u.mem[8'h40 + 8'(k * 16)]}, 9'h03C);
      chk({1'b0, far_u.mem[8'h41 + 8'(k * 16)]}, 9'h0C1);
      chk(payload_len_o, 9'h003);
      rd(PFC_ADDR_IRQ_STAT, (k == 0) ? 8'h04 : 8'h02);
      wr(PFC_ADDR_IRQ_STAT, 8'h0F);
    end
    $display("Test receive done");
    // Streaming modes: start refused, pulse source, echoed bits
    for (int m = 1; m < 3; m++) begin
      do_reset();
      gp_n = 0;
      sv_n = 0;
      wr(PFC_ADDR_FMT_CFG, 8'(m * 8));
      pulse(4'h8);
      rd(PFC_ADDR_STATUS, 8'h00);
      pulse(4'h2);
      repeat (3) @(posedge sys_clk_i);
      chk(9'(gp_n), (m == 1) ? 9'h001 : 9'h000);
      far_u.send_byte(8'hA5, 1'b1);
      repeat (3) @(posedge sys_clk_i);
      chk(9'(sv_n), 9'h008);
      chk({1'b0, sb_q}, 9'h0A5);
      pulse(4'h1);
      repeat (3) @(posedge sys_clk_i);
      chk(9'(gp_n), 9'h001);
    end
    $display("Test streaming done");
    close_out();
  end
endmodule // tb
